// file: pkg/abx_pkg.sv
// abx_pkg: shared constants and types for the add/and/bit execution block
// assumes: single 250 MHz core clock, no software-visible registers
package abx_pkg;
    // ==========================================
    // widths
    localparam int ABX_DATA_W = 8;
    localparam int ABX_ADDR_W = 7;
    localparam int ABX_BIT_W = 3;
    localparam int ABX_NIB_MSB = 3;
    // ==========================================
    // reset values
    localparam logic [7:0] ABX_ACC_RST = 8'h00;
    localparam logic ABX_FLAG_RST = 1'b0;
    localparam logic [6:0] ABX_ADDR_RST = 7'h00;
    localparam logic [7:0] ABX_DATA_RST = 8'h00;
    // ==========================================
    // destination select
    localparam logic ABX_DEST_ACC = 1'b0;
    localparam logic ABX_DEST_REG = 1'b1;
    // ==========================================
    // operation codes seen by this block
    typedef enum logic [2:0] {
        ABX_OP_ADD_IMM = 3'h0,
        ABX_OP_ADD_REG = 3'h1,
        ABX_OP_AND_IMM = 3'h2,
        ABX_OP_AND_REG = 3'h3,
        ABX_OP_BIT_CLR = 3'h4,
        ABX_OP_BIT_SET = 3'h5,
        ABX_OP_TST_CLR = 3'h6,
        ABX_OP_TST_SET = 3'h7
    } abx_op_t;
endpackage

// file: verification/abx_exec_assertions.sv
// abx_exec_assertions: port-level checks of the execution block
// assumes: bound into abx_exec, one clock domain, reset active low
`timescale 1ns/100ps
module abx_exec_assertions
(
    input wire logic ref_clk, // clock
    input wire logic rst_n, // reset
    input wire logic issue_valid, // strobe
    input wire abx_pkg::abx_op_t issue_op, // op
    input wire logic [7:0] literal, // immediate
    input wire logic [6:0] file_addr, // address
    input wire logic [2:0] bit_sel, // bit
    input wire logic dest_sel, // destination
    input wire logic [7:0] reg_rdata, // read data
    input wire logic [6:0] reg_addr_q, // write address
    input wire logic [7:0] reg_wdata_q, // write data
    input wire logic reg_we_q, // write strobe
    input wire logic [7:0] acc_q, // accumulator
    input wire logic carry_q, // carry
    input wire logic half_carry_flag_q, // half carry
    input wire logic zero_q, // zero
    input wire logic skip_q, // skip
    input wire logic done_q // done
);
    import abx_pkg::*;
    logic [7:0] hit;
    logic sel_bit;
    logic rop;
    // an issue while skip_q stands is squashed and executes nothing
    assign hit = (issue_valid && !skip_q) ? (8'h01 << issue_op) : 8'h00;
    assign sel_bit = reg_rdata[bit_sel];
    assign rop = hit[ABX_OP_ADD_REG] | hit[ABX_OP_AND_REG];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ====
    // properties
    property p_add_imm;
        hit[ABX_OP_ADD_IMM] |=> {carry_q, acc_q} == 9'($past(acc_q)) + 9'($past(literal));
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");
    property p_add_reg;
        hit[ABX_OP_ADD_REG] |=> carry_q == (9'($past(acc_q)) + 9'($past(reg_rdata)) > 9'h0ff);
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("add carry wrong");
    property p_and_imm;
        hit[ABX_OP_AND_IMM] |=> acc_q == ($past(acc_q) & $past(literal)) && $stable(carry_q);
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");
    property p_dest_acc;
        rop && dest_sel == ABX_DEST_ACC |=> !reg_we_q;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("register written");
    property p_dest_reg;
        rop && dest_sel == ABX_DEST_REG |=> reg_we_q && reg_addr_q == $past(file_addr) && $stable(acc_q);
    endproperty
    a_dest_reg: assert property (p_dest_reg) else $error("register not written");
    property p_bit_clr;
        hit[ABX_OP_BIT_CLR] |=> reg_we_q && reg_wdata_q == ($past(reg_rdata) & ~(8'h01 << $past(bit_sel)));
    endproperty
    a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");
    property p_bit_set;
        hit[ABX_OP_BIT_SET] |=> reg_wdata_q == ($past(reg_rdata) | (8'h01 << $past(bit_sel)))
            && $stable({carry_q, half_carry_flag_q, zero_q});
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set wrong");
    property p_tst_clr;
        hit[ABX_OP_TST_CLR] |=> skip_q == !$past(sel_bit) && !reg_we_q && done_q;
    endproperty
    a_tst_clr: assert property (p_tst_clr) else $error("skip if clear wrong");
    property p_tst_set;
        hit[ABX_OP_TST_SET] |=> skip_q == $past(sel_bit) && $stable(zero_q);
    endproperty
    a_tst_set: assert property (p_tst_set) else $error("skip if set wrong");
    property p_squash;
        issue_valid && skip_q |=> !done_q && !reg_we_q && !skip_q && $stable(acc_q);
    endproperty
    a_squash: assert property (p_squash) else $error("squashed instruction ran");
    c_skip: cover property (skip_q);
    c_write: cover property (reg_we_q && done_q);
    c_carry: cover property (hit[ABX_OP_ADD_IMM] ##1 carry_q);
endmodule // abx_exec_assertions
bind abx_exec abx_exec_assertions u_chk (.ref_clk, .rst_n, .issue_valid, .issue_op, .literal,
    .file_addr, .bit_sel, .dest_sel, .reg_rdata, .reg_addr_q, .reg_wdata_q, .reg_we_q, .acc_q,
    .carry_q, .half_carry_flag_q, .zero_q, .skip_q, .done_q);

// file: verification/abx_regfile_model.sv
// abx_regfile_model: 128-byte data register file facing the block
// assumes: combinational read, write lands at the clock edge
`timescale 1ns/100ps
module abx_regfile_model
(
    input wire logic ref_clk, // clock
    input wire logic [6:0] file_addr, // read address
    output logic [7:0] reg_rdata, // read data
    input wire logic [6:0] reg_addr_q, // write address
    input wire logic [7:0] reg_wdata_q, // write data
    input wire logic reg_we_q // write strobe
);
    logic [7:0] mem [128];
    assign reg_rdata = mem[file_addr];
    always @(posedge ref_clk) if (reg_we_q) mem[reg_addr_q] <= reg_wdata_q;
endmodule // abx_regfile_model

// file: verification/tb_add_and_bit_instruction_exec.sv
// tb_add_and_bit_instruction_exec: scenario tests of the execution block
// assumes: register file model beside the block, inputs driven at negedge
`timescale 1ns/100ps
module tb_add_and_bit_instruction_exec;
    import abx_pkg::*;
    localparam logic [7:0] PAT = 8'h5a;
    logic ref_clk = 1'b0, rst_n = 1'b0, issue_valid = 1'b0, dest_sel = 1'b0;
    abx_op_t issue_op = ABX_OP_ADD_IMM;
    logic [7:0] literal = 8'h00, reg_rdata, reg_wdata_q, acc_q;
    logic [6:0] file_addr = 7'h00, reg_addr_q;
    logic [2:0] bit_sel = 3'h0;
    logic reg_we_q, carry_q, half_carry_flag_q, zero_q, skip_q, done_q;
    int bad_count = 0, n_tests = 0, cyc = 0;
    always #2 ref_clk = ~ref_clk;
    abx_exec dut (.ref_clk, .rst_n, .issue_valid, .issue_op, .literal, .file_addr, .bit_sel,
        .dest_sel, .reg_rdata, .reg_addr_q, .reg_wdata_q, .reg_we_q, .acc_q, .carry_q,
        .half_carry_flag_q, .zero_q, .skip_q, .done_q);
    abx_regfile_model u_rf (.ref_clk, .file_addr, .reg_rdata, .reg_addr_q, .reg_wdata_q, .reg_we_q);
    // ====
    // helpers
    function automatic logic [15:0] st();
        return {done_q, skip_q, reg_we_q, 2'h0, carry_q, half_carry_flag_q, zero_q, acc_q};
    endfunction
    function automatic logic [15:0] wr();
        return {reg_we_q, reg_addr_q, reg_wdata_q};
    endfunction
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task issue(input abx_op_t op, input logic [7:0] k, input logic [6:0] a, input int b, input logic d);
        issue_valid = 1'b1;
        issue_op = op;
        literal = k;
        file_addr = a;
        bit_sel = 3'(b);
        dest_sel = d;
        @(negedge ref_clk);
    endtask
    task idle();
        issue_valid = 1'b0;
        @(negedge ref_clk);
    endtask
    task stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ====
    // scenarios
    task t_imm();
        issue(ABX_OP_ADD_IMM, 8'hff, 7'h00, 0, 1'b1);
        chk(st(), 16'h80ff);
        issue(ABX_OP_ADD_IMM, 8'h01, 7'h00, 0, 1'b0);
        chk(st(), 16'h8700);
        issue(ABX_OP_AND_IMM, 8'h0f, 7'h00, 0, 1'b0);
        chk(st(), 16'h8700);
        issue(ABX_OP_ADD_IMM, 8'h88, 7'h00, 0, 1'b0);
        chk(st(), 16'h8088);
        issue(ABX_OP_AND_IMM, 8'h80, 7'h00, 0, 1'b1);
        chk(st(), 16'h8080);
        idle();
        $display("immediate test ended");
    endtask
    task t_reg();
        u_rf.mem[5] = 8'h79;
        u_rf.mem[6] = 8'h80;
        issue(ABX_OP_ADD_REG, 8'h00, 7'h05, 0, ABX_DEST_REG);
        chk(st(), 16'ha080);
        chk(wr(), 16'h85f9);
        idle();
        issue(ABX_OP_ADD_REG, 8'h00, 7'h06, 0, ABX_DEST_ACC);
        chk(st(), 16'h8500);
        issue(ABX_OP_AND_REG, 8'h00, 7'h05, 0, ABX_DEST_REG);
        chk(st(), 16'ha500);
        chk(wr(), 16'h8500);
        issue(ABX_OP_ADD_IMM, 8'h08, 7'h00, 0, 1'b0);
        chk(st(), 16'h8008);
        issue(ABX_OP_ADD_IMM, 8'h08, 7'h00, 0, 1'b0);
        chk(st(), 16'h8210);
        idle();
        $display("register test ended");
    endtask
    task t_bits();
        for (int b = 0; b < 8; b++)
        begin
            u_rf.mem[9] = PAT;
            issue(ABX_OP_TST_CLR, 8'h00, 7'h09, b, 1'b0);
            chk(st(), 16'h8210 | {1'b0, !PAT[b], 14'h0});
            idle();
            issue(ABX_OP_TST_SET, 8'h00, 7'h09, b, 1'b0);
            chk(st(), 16'h8210 | {1'b0, PAT[b], 14'h0});
            idle();
            issue(ABX_OP_BIT_CLR, 8'h00, 7'h09, b, 1'b0);
            chk(wr(), {1'b1, 7'h09, PAT & ~(8'h01 << b)});
            issue(ABX_OP_BIT_SET, 8'h00, 7'h09, b, 1'b1);
            chk(wr(), {1'b1, 7'h09, PAT | (8'h01 << b)});
            chk(st(), 16'ha210);
            idle();
        end
        $display("bit test ended");
    endtask
    task t_squash();
        u_rf.mem[9] = 8'h00;
        issue(ABX_OP_TST_CLR, 8'h00, 7'h09, 0, 1'b0);
        chk(st(), 16'hc210);
        issue(ABX_OP_ADD_IMM, 8'h01, 7'h00, 0, 1'b0);
        chk(st(), 16'h0210);
        idle();
        $display("squash test ended");
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            bad_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        t_imm();
        t_reg();
        t_bits();
        t_squash();
        stop_test();
    end
endmodule // tb_add_and_bit_instruction_exec

// file: verilog/abx_adder.sv
// abx_adder: 8-bit adder with carry out of bit 7 and bit 3
// assumes: purely combinational, used by the execution unit
`timescale 1ns/100ps
module abx_adder
(
    input wire logic [7:0] a, // first operand
    input wire logic [7:0] b, // second operand
    output logic [7:0] sum, // 8-bit sum
    output logic carry, // carry out of bit 7
    output logic half_carry // carry out of bit 3
);
    import abx_pkg::*;
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    always_comb
    begin
        low_sum = {1'b0, a[ABX_NIB_MSB:0]} + {1'b0, b[ABX_NIB_MSB:0]};
        full_sum = {1'b0, a} + {1'b0, b};
        sum = full_sum[7:0];
        carry = full_sum[8];
        half_carry = low_sum[4];
    end
endmodule // abx_adder

// file: verilog/abx_bit_unit.sv
// abx_bit_unit: bit select, bit clear/set and bit test on a register byte
// assumes: purely combinational, used by the execution unit
`timescale 1ns/100ps
module abx_bit_unit
(
    input wire logic [7:0] data, // register byte
    input wire logic [2:0] bit_sel, // selected bit position 0..7
    output logic [7:0] cleared, // byte with selected bit forced to 0
    output logic [7:0] set, // byte with selected bit forced to 1
    output logic bit_value // value of the selected bit
);
    import abx_pkg::*;
    logic [7:0] mask;
    always_comb
    begin
        mask = 8'h01 << bit_sel;
        cleared = data & ~mask;
        set = data | mask;
        bit_value = data[bit_sel];
    end
endmodule // abx_bit_unit

// file: verilog/abx_exec.sv
// abx_exec: executes add, and, bit clear/set and bit-test-skip instructions
// assumes: sequencer presents one decoded instruction with issue_valid for
// one cycle; register file gives read data combinationally for file_addr
// and takes a write on reg_we_q; skip_q tells the sequencer to squash the
// already fetched next instruction and run a no-operation instead.
// the instruction issued in the cycle after a taken skip is dropped here
// as well, so a sequencer that does not squash it still sees a no-operation;
// a register write lands one cycle after issue, with no forwarding, so a
// dependent read must wait one cycle.
`timescale 1ns/100ps
module abx_exec
(
    input wire logic ref_clk, // core clock, 250 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic issue_valid, // one-cycle strobe: instruction presented
    input wire abx_pkg::abx_op_t issue_op, // decoded operation
    input wire logic [7:0] literal, // 8-bit immediate value
    input wire logic [6:0] file_addr, // register file address
    input wire logic [2:0] bit_sel, // bit position for bit ops
    input wire logic dest_sel, // 0 accumulator, 1 register
    input wire logic [7:0] reg_rdata, // register file read data
    output logic [6:0] reg_addr_q, // register file write address
    output logic [7:0] reg_wdata_q, // register file write data
    output logic reg_we_q, // one-cycle register write strobe
    output logic [7:0] acc_q, // accumulator
    output logic carry_q, // carry flag
    output logic half_carry_flag_q, // half carry flag
    output logic zero_q, // zero flag
    output logic skip_q, // one-cycle pulse: squash next instruction
    output logic done_q // one-cycle pulse: instruction completed
);
    import abx_pkg::*;

    // ==========================================
    // datapath
    logic [7:0] add_b;
    logic [7:0] and_b;
    logic [7:0] sum;
    logic add_carry;
    logic add_half;
    logic [7:0] bit_cleared;
    logic [7:0] bit_setv;
    logic bit_value;

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    // ==========================================
    // operand select
    always_comb
    begin
        add_b = reg_rdata;
        unique case (issue_op)
            ABX_OP_ADD_IMM, ABX_OP_AND_IMM:
            begin
                add_b = literal;
            end
            ABX_OP_ADD_REG, ABX_OP_AND_REG, ABX_OP_BIT_CLR, ABX_OP_BIT_SET,
            ABX_OP_TST_CLR, ABX_OP_TST_SET:
            begin
                add_b = reg_rdata;
            end
        endcase
    end

    assign and_b = add_b & acc_q;

    // ==========================================
    // shared adder
    abx_adder u_adder
    (
        .a(acc_q),
        .b(add_b),
        .sum(sum),
        .carry(add_carry),
        .half_carry(add_half)
    );

    // ==========================================
    // bit select, clear and set
    abx_bit_unit u_bits
    (
        .data(reg_rdata),
        .bit_sel(bit_sel),
        .cleared(bit_cleared),
        .set(bit_setv),
        .bit_value(bit_value)
    );

    // ==========================================
    // result routing
    logic [7:0] result;
    logic to_reg;
    logic to_acc;
    logic arith;
    always_comb
    begin
        result = 8'h00;
        to_reg = 1'b0;
        to_acc = 1'b0;
        arith = 1'b0;
        unique case (issue_op)
            ABX_OP_ADD_IMM:
            begin
                result = sum;
                to_acc = 1'b1;
                arith = 1'b1;
            end
            ABX_OP_ADD_REG:
            begin
                result = sum;
                to_acc = (dest_sel == ABX_DEST_ACC);
                to_reg = (dest_sel == ABX_DEST_REG);
                arith = 1'b1;
            end
            ABX_OP_AND_IMM:
            begin
                result = and_b;
                to_acc = 1'b1;
            end
            ABX_OP_AND_REG:
            begin
                result = and_b;
                to_acc = (dest_sel == ABX_DEST_ACC);
                to_reg = (dest_sel == ABX_DEST_REG);
            end
            ABX_OP_BIT_CLR:
            begin
                result = bit_cleared;
                to_reg = 1'b1;
            end
            ABX_OP_BIT_SET:
            begin
                result = bit_setv;
                to_reg = 1'b1;
            end
            ABX_OP_TST_CLR, ABX_OP_TST_SET:
            begin
                result = reg_rdata;
            end
        endcase
    end

    // ==========================================
    // flag update and skip decode
    logic upd_zero;
    logic skip_hit;
    always_comb
    begin
        upd_zero = 1'b0;
        skip_hit = 1'b0;
        unique case (issue_op)
            ABX_OP_ADD_IMM, ABX_OP_ADD_REG:
            begin
                upd_zero = 1'b1;
            end
            ABX_OP_AND_IMM, ABX_OP_AND_REG:
            begin
                upd_zero = 1'b1;
            end
            ABX_OP_BIT_CLR, ABX_OP_BIT_SET:
            begin
                // bit ops leave every flag alone
                upd_zero = 1'b0;
            end
            ABX_OP_TST_CLR:
            begin
                skip_hit = !bit_value;
            end
            ABX_OP_TST_SET:
            begin
                skip_hit = bit_value;
            end
        endcase
    end

    // ==========================================
    // squash of the instruction after a taken skip
    typedef enum logic {RUN_ST, SQUASH_ST} abx_phase_t;
    abx_phase_t phase_q;
    logic take;
    assign take = issue_valid && (phase_q == RUN_ST);
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_q <= RUN_ST;
        else
        begin
            unique case (phase_q)
                RUN_ST:
                begin
                    if (take && skip_hit)
                        phase_q <= SQUASH_ST;
                end
                SQUASH_ST:
                begin
                    phase_q <= RUN_ST;
                end
            endcase
        end
    end

    // ==========================================
    // accumulator
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_q <= ABX_ACC_RST;
        else if (take && to_acc)
            acc_q <= result;
    end

    // ==========================================
    // register file write strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_we_q <= 1'b0;
        else
            reg_we_q <= take && to_reg;
    end

    // ==========================================
    // register file write address and data
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_addr_q <= ABX_ADDR_RST;
            reg_wdata_q <= ABX_DATA_RST;
        end
        else if (take && to_reg)
        begin
            reg_addr_q <= file_addr;
            reg_wdata_q <= result;
        end
    end

    // ==========================================
    // carry flag
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            carry_q <= ABX_FLAG_RST;
        else if (take && arith)
            carry_q <= add_carry;
    end

    // ==========================================
    // half carry flag
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            half_carry_flag_q <= ABX_FLAG_RST;
        else if (take && arith)
            half_carry_flag_q <= add_half;
    end

    // ==========================================
    // zero flag
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            zero_q <= ABX_FLAG_RST;
        else if (take && upd_zero)
            zero_q <= is_zero(result);
    end

    // ==========================================
    // completion
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            done_q <= 1'b0;
        else
            done_q <= take;
    end

    // ==========================================
    // skip request
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            skip_q <= 1'b0;
        else
            skip_q <= take && skip_hit;
    end
endmodule // abx_exec
